// *** copwd_top.sv ***
// Watchdog with a classic Wishbone register slave and a reset pulse driver.
// Assumes all control inputs are synchronous to clk_i, the reference clock.
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ps
// How it works
// - 6-bit counter fed by 12-bit prescaler.
// - Unserviced, overflow forces reset at timeout.
// - Reset clears rate select; long timeout.
// - Service write clears counter, prescaler upper.
// - Service read returns reset vector low.
// - Overflow: pin low 32 cycles, cause flag.
// - Monitor mode test voltage disables watchdog.
// - Break with reset test voltage disables.
// - Stop instruction clears the prescaler.
// - Stop mode gates counting off.
// - Prescaler cleared 4096 cycles after power-up.
// - Internal reset clears prescaler and counter.
// - Reset vector fetch clears the prescaler.
// - Disable bit set means no reset.
// - No processor interrupt; reset only.
// - Counting continues during wait mode.
module copwd_top
  import copwd_pkg::*;
(
  input  wire logic        clk_i,           // Reference clock.
  input  wire logic        rst_i,           // Internal reset, high.
  input  wire logic        wb_cyc_i,        // Wishbone cycle.
  input  wire logic        wb_stb_i,        // Wishbone strobe.
  input  wire logic        wb_we_i,         // Wishbone write.
  input  wire logic [17:0] wb_adr_i,        // Wishbone byte address.
  input  wire logic [3:0]  wb_sel_i,        // Wishbone byte selects.
  input  wire logic [31:0] wb_dat_i,        // Wishbone write data.
  output logic      [31:0] wb_dat_o,        // Wishbone read data.
  output logic             wb_ack_o,        // Wishbone acknowledge.
  input  wire logic [7:0]  reset_vec_lo_i,  // Low byte of the reset vector.
  input  wire logic        monitor_i,       // Monitor mode.
  input  wire logic        break_i,         // Break state.
  input  wire logic        tst_rst_i,       // Test voltage on reset pin.
  input  wire logic        tst_irq_i,       // Test voltage on interrupt pin.
  input  wire logic        stop_i,          // Stop mode level.
  input  wire logic        stop_exec_i,     // Stop instruction pulse.
  input  wire logic        vector_fetch_i,  // Reset vector fetch pulse.
  input  wire logic        rst_pin_i,       // Sensed reset pin level.
  output logic             rst_pin_o,       // Reset pin drive level.
  output logic             rst_pin_oe_n_o,  // Reset pin enable, low drives.
  output logic             sys_reset_o,     // Reset request to the system.
  output logic             irq_o            // Cause flag event line.
);

  // ---------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------
  copwd_chain_if ch ();                 // Link to the counter chain.

  logic        req;                     // New bus request this cycle.
  logic        wr;                      // New bus write this cycle.
  logic        rd;                      // New bus read this cycle.
  logic [15:0] idx;                     // Register index of the request.
  logic        cfg_rate_q;              // Timeout rate select.
  logic        cfg_dis_q;               // Watchdog disable.
  logic        cause_q;                 // Watchdog reset cause flag.
  logic        mask_q;                  // Event mask for the cause flag.
  logic        svc_q;                   // Registered service strobe.
  logic [5:0]  pulse_cnt_q;             // Remaining reset pulse cycles.
  logic [5:0]  pulse_cnt_d;             // Next pulse count.
  logic [12:0] por_cnt_q;               // Cycles since reset release.
  logic        por_fire;                // Power-up prescaler clear.
  logic        tst_block;               // Test voltage blocks counting.
  logic        ack_q;                   // Bus acknowledge.
  logic [31:0] dat_q;                   // Bus read data.
  logic        oe_n_q;                  // Pin enable, low while driving.
  logic        pin_q;                   // Pin level, always low when driven.
  logic        sysrst_q;                // Reset request level.
  logic        irq_q;                   // Event line.

  // ---------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------
  // A request is new while cyc and stb stand and ack has not been given.
  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr  = req && wb_we_i;
  assign rd  = req && !wb_we_i;
  assign idx = wb_adr_i[17:2];

  // Acknowledge one cycle after the request; it drops the cycle after.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  // Read data is captured with the request; unmapped reads give zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= '0;
    end else if (rd) begin
      dat_q <= '0;
      unique case (idx)
        IDX_CONFIG: begin
          dat_q[BIT_RATE]    <= cfg_rate_q;
          dat_q[BIT_DISABLE] <= cfg_dis_q;
        end
        IDX_STATUS: begin
          dat_q[BIT_CAUSE] <= cause_q;
        end
        IDX_MASK: begin
          dat_q[BIT_CAUSE] <= mask_q;
        end
        IDX_COUNT: begin
          dat_q[PRE_W+COP_W-1:0] <= {ch.cop, ch.pre};
          dat_q[BIT_PIN]         <= rst_pin_i;
        end
        IDX_SERVICE: begin
          // The location overlaps the vector, so a read has no side effect.
          dat_q[7:0] <= reset_vec_lo_i;
        end
        default: begin
          dat_q <= '0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // Configuration and mask registers
  // ---------------------------------------------------------------------
  // Reset selects the long timeout and leaves the watchdog enabled.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_rate_q <= 1'b0;
      cfg_dis_q  <= 1'b0;
    end else if (wr && idx == IDX_CONFIG && wb_sel_i[0]) begin
      cfg_rate_q <= wb_dat_i[BIT_RATE];
      cfg_dis_q  <= wb_dat_i[BIT_DISABLE];
    end
  end

  // Mask register of the same layout as the status register.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_q <= 1'b0;
    end else if (wr && idx == IDX_MASK && wb_sel_i[0]) begin
      mask_q <= wb_dat_i[BIT_CAUSE];
    end
  end

  // ---------------------------------------------------------------------
  // Service strobe
  // ---------------------------------------------------------------------
  // Any write to the service location counts, whatever the data or lanes.
  // Registering it lets the chain see the clear ahead of the overflow test.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      svc_q <= 1'b0;
    end else begin
      svc_q <= wr && (idx == IDX_SERVICE);
    end
  end

  // ---------------------------------------------------------------------
  // Power-up delay
  // ---------------------------------------------------------------------
  // Counts once from reset release and fires a single prescaler clear.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      por_cnt_q <= '0;
    end else if (por_cnt_q != POR_CYCLES) begin
      por_cnt_q <= por_cnt_q + 1'b1;
    end
  end
  assign por_fire = (por_cnt_q == POR_CYCLES - 1'b1);

  // ---------------------------------------------------------------------
  // Chain controls
  // ---------------------------------------------------------------------
  // Monitor mode honours either pin; the break state only the reset pin.
  assign tst_block = (monitor_i && (tst_rst_i || tst_irq_i)) ||
                     (break_i && tst_rst_i);
  // Wait mode is not an input: the chain simply keeps counting in it.
  assign ch.count_en    = !stop_i && !cfg_dis_q && !tst_block;
  assign ch.clear_pre   = stop_exec_i || vector_fetch_i || por_fire;
  assign ch.clear_upper = svc_q;
  // The chain is held clear while this block drives its own reset pulse.
  assign ch.clear_all   = (pulse_cnt_q != '0);
  assign ch.rate_sel    = cfg_rate_q;

  copwd_chain u_chain (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ch    (ch)
  );

  // ---------------------------------------------------------------------
  // Reset pulse
  // ---------------------------------------------------------------------
  // An overflow loads the pulse length; the pin is driven while it runs.
  always_comb begin
    pulse_cnt_d = pulse_cnt_q;
    if (ch.overflow) begin
      pulse_cnt_d = PULSE_CYCLES;
    end else if (pulse_cnt_q != '0) begin
      pulse_cnt_d = pulse_cnt_q - 1'b1;
    end
  end

  // Pulse counter and the pin and request flops follow it directly.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pulse_cnt_q <= '0;
      oe_n_q      <= 1'b1;
      sysrst_q    <= 1'b0;
      pin_q       <= 1'b0;
    end else begin
      pulse_cnt_q <= pulse_cnt_d;
      oe_n_q      <= (pulse_cnt_d == '0);
      sysrst_q    <= (pulse_cnt_d != '0);
      pin_q       <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------
  // Cause flag and event line
  // ---------------------------------------------------------------------
  // Sticky flag, cleared by reading the status register; a new overflow in
  // the clearing cycle wins so that no timeout goes unrecorded.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cause_q <= 1'b0;
    end else if (ch.overflow) begin
      cause_q <= 1'b1;
    end else if (rd && idx == IDX_STATUS) begin
      cause_q <= 1'b0;
    end
  end

  // This line only mirrors the masked flag; nothing here requests a
  // processor interrupt, the timeout acts through the reset alone.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= cause_q && mask_q;
    end
  end

  assign wb_ack_o       = ack_q;
  assign wb_dat_o       = dat_q;
  assign rst_pin_o      = pin_q;
  assign rst_pin_oe_n_o = oe_n_q;
  assign sys_reset_o    = sysrst_q;
  assign irq_o          = irq_q;

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  property p_pulse_len;
    @(posedge clk_i) disable iff (rst_i)
    $fell(oe_n_q) |-> (!oe_n_q [*8]) ##24 !oe_n_q ##1 oe_n_q;
  endproperty
  a_pulse_len: assert property (p_pulse_len)
    else $error("reset pin pulse is not 32 cycles");

  property p_cause_set;
    @(posedge clk_i) disable iff (rst_i)
    ch.overflow |=> cause_q ##0 !oe_n_q ##0 sysrst_q;
  endproperty
  a_cause_set: assert property (p_cause_set)
    else $error("overflow did not record cause and drive the pin");

  property p_monitor_block;
    @(posedge clk_i) disable iff (rst_i)
    (monitor_i && (tst_rst_i || tst_irq_i)) |-> !ch.count_en;
  endproperty
  a_monitor_block: assert property (p_monitor_block)
    else $error("watchdog counted under monitor test voltage");

  property p_break_block;
    @(posedge clk_i) disable iff (rst_i)
    (break_i && !monitor_i && !stop_i && !cfg_dis_q)
      |-> (ch.count_en == !tst_rst_i);
  endproperty
  a_break_block: assert property (p_break_block)
    else $error("break state gating of the watchdog is wrong");

  property p_disabled_quiet;
    @(posedge clk_i) disable iff (rst_i)
    (cfg_dis_q && pulse_cnt_q == '0) |=> oe_n_q && !sysrst_q;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("disabled watchdog produced a reset");

  property p_por_clear;
    @(posedge clk_i) disable iff (rst_i)
    por_fire |=> (ch.pre == '0) ##1 (por_cnt_q == POR_CYCLES);
  endproperty
  a_por_clear: assert property (p_por_clear)
    else $error("power-up prescaler clear missing");

  property p_service_wins;
    @(posedge clk_i) disable iff (rst_i)
    (wr && idx == IDX_SERVICE) |=> !ch.overflow ##1 (ch.cop == '0);
  endproperty
  a_service_wins: assert property (p_service_wins)
    else $error("service did not beat a pending overflow");

  property p_rate_reset;
    @(posedge clk_i)
    rst_i |=> !cfg_rate_q && !cause_q;
  endproperty
  a_rate_reset: assert property (p_rate_reset)
    else $error("reset left rate select or cause set");

  // A read of the service location overlaps the vector and must never be
  // mistaken for a service, or a stray read would hide a runaway program.
  property p_read_quiet;
    @(posedge clk_i) disable iff (rst_i)
    (rd && idx == IDX_SERVICE) |=> !svc_q;
  endproperty
  a_read_quiet: assert property (p_read_quiet)
    else $error("service read acted as a service");

  property p_stop_gate;
    @(posedge clk_i) disable iff (rst_i)
    stop_i |-> !ch.count_en;
  endproperty
  a_stop_gate: assert property (p_stop_gate)
    else $error("watchdog counted in stop mode");

  property p_event_line;
    @(posedge clk_i) disable iff (rst_i)
    (cause_q && mask_q) |=> irq_q;
  endproperty
  a_event_line: assert property (p_event_line)
    else $error("masked cause flag did not raise the event line");

  property p_reset_quiet;
    @(posedge clk_i)
    rst_i |=> oe_n_q && !sysrst_q && !irq_q;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("internal reset left the pin or event line active");

endmodule

// *** copwd_pkg.sv ***
// Constants shared by the watchdog counter chain and its register front end.
// Assumes one clock, clk_i, which doubles as the reference clock.
package copwd_pkg;

  // ---------------------------------------------------------------------
  // Counter chain
  // ---------------------------------------------------------------------
  localparam int PRE_W        = 12;      // Width of the system prescaler.
  localparam int COP_W        = 6;       // Width of the watchdog counter.
  localparam int SVC_LO       = 4;       // Lowest prescaler bit a service clears.
  localparam int SVC_HI       = 11;      // Highest prescaler bit a service clears.
  localparam int LONG_CYCLES  = 262128;  // Timeout with rate select at 0.
  localparam int SHORT_CYCLES = 8176;    // Timeout with rate select at 1.
  // The low prescaler bits survive a service, so the printed figures sit
  // one slack short of a power of two; the counter top is derived from it.
  localparam int SVC_SLACK    = 2 ** SVC_LO;
  localparam int PRE_SPAN     = 2 ** PRE_W;
  localparam logic [COP_W-1:0] LONG_TOP  =
    COP_W'((LONG_CYCLES + SVC_SLACK) / PRE_SPAN - 1);
  localparam logic [COP_W-1:0] SHORT_TOP =
    COP_W'((SHORT_CYCLES + SVC_SLACK) / PRE_SPAN - 1);
  localparam logic [PRE_W-1:0] PRE_MAX   = {PRE_W{1'b1}};

  // ---------------------------------------------------------------------
  // Reset pulse and power-up delay
  // ---------------------------------------------------------------------
  localparam logic [5:0]  PULSE_CYCLES = 6'h20;   // Pin low time, 32 cycles.
  localparam logic [12:0] POR_CYCLES   = 13'h1000; // Power-up clear, 4096.

  // ---------------------------------------------------------------------
  // Register indexes; byte address is four times the index
  // ---------------------------------------------------------------------
  localparam logic [15:0] IDX_CONFIG  = 16'h0000;
  localparam logic [15:0] IDX_STATUS  = 16'h0001;
  localparam logic [15:0] IDX_MASK    = 16'h0002;
  localparam logic [15:0] IDX_COUNT   = 16'h0003;
  localparam logic [15:0] IDX_SERVICE = 16'hffff;
  localparam int BIT_RATE    = 0;   // Configuration: timeout rate select.
  localparam int BIT_DISABLE = 1;   // Configuration: watchdog disable.
  localparam int BIT_CAUSE   = 0;   // Status and mask: watchdog reset cause.
  localparam int BIT_PIN     = 18;  // Count register: sensed reset pin level.

  // True once every bit of the top pattern is set in the watchdog counter.
  function automatic logic copwd_top_hit(input logic [COP_W-1:0] cnt,
                                         input logic [COP_W-1:0] top);
    copwd_top_hit = ((cnt & top) == top);
  endfunction

endpackage

// *** copwd_chain_if.sv ***
// Interface between the watchdog register front end and its counter chain.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface copwd_chain_if;
  import copwd_pkg::*;
  logic             clear_all;   // Clears prescaler and watchdog counter.
  logic             clear_pre;   // Clears the whole prescaler.
  logic             clear_upper; // Clears counter and upper prescaler bits.
  logic             count_en;    // Counting allowed this cycle.
  logic             rate_sel;    // One selects the short timeout.
  logic             overflow;    // Timeout reached this cycle.
  logic [PRE_W-1:0] pre;         // Prescaler value.
  logic [COP_W-1:0] cop;         // Watchdog counter value.

  modport ctl   (output clear_all, clear_pre, clear_upper, count_en,
                 rate_sel, input overflow, pre, cop);
  modport chain (input clear_all, clear_pre, clear_upper, count_en,
                 rate_sel, output overflow, pre, cop);
endinterface

// *** copwd_chain.sv ***
// Prescaler and watchdog counter of the watchdog.
// Assumes the controls arrive registered on the same clock.
`timescale 1ns/1ps
module copwd_chain
  import copwd_pkg::*;
(
  input  wire logic   clk_i,
  input  wire logic   rst_i,
  copwd_chain_if.chain ch
);

  logic [PRE_W-1:0] pre_q;   // Free-running system prescaler.
  logic [COP_W-1:0] cop_q;   // Watchdog counter fed by the prescaler carry.
  logic             wrap;    // Prescaler carry this cycle.

  // ---------------------------------------------------------------------
  // Carry and overflow
  // ---------------------------------------------------------------------
  // A clear of any kind swallows the carry of the same cycle, so neither
  // the watchdog counter nor the overflow moves while the prescaler resets.
  // Without this a power-up clear landing on a carry would bump the counter
  // and shorten, or for the long rate wrap away, the next timeout.
  assign wrap = ch.count_en && (pre_q == PRE_MAX) && !ch.clear_all &&
                !ch.clear_pre && !ch.clear_upper;
  assign ch.overflow = wrap &&
                       copwd_top_hit(cop_q, ch.rate_sel ? SHORT_TOP :
                                                          LONG_TOP);
  assign ch.pre = pre_q;
  assign ch.cop = cop_q;

  // Prescaler: whole clears first, then the service clear of its upper bits.
  always_ff @(posedge clk_i) begin
    if (rst_i || ch.clear_all) begin
      pre_q <= '0;
    end else if (ch.clear_pre) begin
      pre_q <= '0;
    end else if (ch.clear_upper) begin
      pre_q[SVC_HI:SVC_LO] <= '0;
    end else if (ch.count_en) begin
      pre_q <= pre_q + 1'b1;
    end
  end

  // Watchdog counter: advances only on the prescaler carry.
  always_ff @(posedge clk_i) begin
    if (rst_i || ch.clear_all || ch.clear_upper) begin
      cop_q <= '0;
    end else if (wrap) begin
      cop_q <= cop_q + 1'b1;
    end
  end

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  property p_service_clear;
    @(posedge clk_i) disable iff (rst_i)
    ch.clear_upper |=> (cop_q == '0) && (pre_q[SVC_HI:SVC_LO] == '0);
  endproperty
  a_service_clear: assert property (p_service_clear)
    else $error("service did not clear the counter chain");

  property p_pre_clear;
    @(posedge clk_i) disable iff (rst_i)
    ch.clear_pre |=> (pre_q == '0);
  endproperty
  a_pre_clear: assert property (p_pre_clear)
    else $error("prescaler clear did not take effect");

  property p_gated_hold;
    @(posedge clk_i) disable iff (rst_i)
    (!ch.count_en && !ch.clear_all && !ch.clear_pre && !ch.clear_upper)
      |=> $stable(pre_q) && $stable(cop_q);
  endproperty
  a_gated_hold: assert property (p_gated_hold)
    else $error("counter moved while counting was gated");

  property p_overflow_point;
    @(posedge clk_i) disable iff (rst_i)
    ch.overflow |-> (pre_q == PRE_MAX) &&
      (ch.rate_sel ? cop_q[0] : (cop_q == LONG_TOP));
  endproperty
  a_overflow_point: assert property (p_overflow_point)
    else $error("overflow away from the timeout point");

  property p_internal_reset;
    @(posedge clk_i)
    rst_i |=> (pre_q == '0) && (cop_q == '0);
  endproperty
  a_internal_reset: assert property (p_internal_reset)
    else $error("reset left the counter chain non-zero");

endmodule

// *** test_copwd_top.sv ***
// Self-checking bench for the watchdog block with its Wishbone registers.
// Assumes the design files and copwd_pkg are compiled before this file.
`timescale 1ns/1ps
module test_copwd_top
  import copwd_pkg::*;
;
  // ---------------------------------------------------------------------
  // Stimulus and observation signals
  // ---------------------------------------------------------------------
  logic        clk_i = 1'b0;        // Reference clock, 40 ns period.
  logic        rst_i = 1'b1;        // Internal reset, held at start.
  logic        wb_cyc_i = 1'b0;     // Bus cycle.
  logic        wb_stb_i = 1'b0;     // Bus strobe.
  logic        wb_we_i = 1'b0;      // Bus direction.
  logic [17:0] wb_adr_i = '0;       // Byte address.
  logic [3:0]  wb_sel_i = '0;       // Lane selects.
  logic [31:0] wb_dat_i = '0;       // Write data.
  logic [31:0] wb_dat_o;            // Read data.
  logic        wb_ack_o;            // Acknowledge.
  logic [7:0]  vec_lo = 8'h00;      // Reset vector low byte.
  logic [3:0]  mode = 4'h0;         // Monitor, break, pin and irq test.
  logic        stop_i = 1'b0;       // Stop mode level.
  logic        stop_exec_i = 1'b0;  // Stop instruction pulse.
  logic        fetch_i = 1'b0;      // Vector fetch pulse.
  logic        pin_oe_n, pin_o, pin_w, sys_reset_o, irq_o, rst_q;
  logic [31:0] q_e[$], q_m[$];      // Expected read data and care mask.
  logic [31:0] rnd = 32'h62;        // Xorshift state, seeded with 98.
  int          n_fail = 0, cmp_count = 0, n_rst = 0, i, j, k;
  // The reset pin has a pull-up, so it reads high unless we drive it.
  assign pin_w = pin_oe_n ? 1'b1 : pin_o;
  always #20 clk_i = ~clk_i;

  copwd_top u_copwd_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .reset_vec_lo_i(vec_lo), .monitor_i(mode[3]),
    .break_i(mode[2]), .tst_rst_i(mode[1]), .tst_irq_i(mode[0]),
    .stop_i(stop_i), .stop_exec_i(stop_exec_i), .vector_fetch_i(fetch_i),
    .rst_pin_i(pin_w), .rst_pin_o(pin_o), .rst_pin_oe_n_o(pin_oe_n),
    .sys_reset_o(sys_reset_o), .irq_o(irq_o));

  // ---------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------
  function automatic logic [31:0] xs();
    rnd = rnd ^ (rnd << 13);
    rnd = rnd ^ (rnd >> 17);
    rnd = rnd ^ (rnd << 5);
    return rnd;
  endfunction

  task automatic stop_test();
    if (n_fail == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One classic cycle; the request stands until ack is sampled high.
  task automatic wb(input logic we, input logic [17:0] a,
                    input logic [31:0] d);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    for (n = 0; n < 100 && wb_ack_o !== 1'b1; n++) @(posedge clk_i);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n == 100) begin
      n_fail++;
      stop_test();
    end
  endtask

  // A read notes its expectation first; the monitor compares at ack.
  task automatic rd(input logic [17:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    q_e.push_back(e);
    q_m.push_back(m);
    wb(1'b0, a, 32'h0);
  endtask

  // Idle for n cycles and check how many reset pulses appeared.
  task automatic idle(input int n, input int exp);
    int base;
    base = n_rst;
    repeat (n) @(posedge clk_i);
    check(n_rst - base, exp);
  endtask

  // ---------------------------------------------------------------------
  // Monitor: read data against the oldest note, and reset pulse count
  // ---------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      if (q_e.size() == 0)
        check(32'hdead, 32'h0);
      else
        check(wb_dat_o & q_m.pop_front(), q_e.pop_front());
    end
    rst_q <= sys_reset_o;
    if (sys_reset_o === 1'b1 && rst_q === 1'b0)
      n_rst++;
  end

  // ---------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i  <= 1'b0;
    vec_lo <= 8'(xs());
    rd(18'h00000, 32'h0, 32'h3);
    rd(18'h00004, 32'h0, 32'hffffffff);
    rd(18'h00008, 32'h0, 32'hffffffff);
    wb(1'b1, 18'h00010, xs());
    rd(18'h00010, 32'h0, 32'hffffffff);
    rd(18'h3fffc, {24'h0, vec_lo}, 32'hffffffff);
    wb(1'b1, 18'h00000, 32'h1);
    wb(1'b1, 18'h00008, 32'h1);
    rd(18'h00000, 32'h1, 32'h3);
    // Let the counter climb past the power-up clear until the watchdog
    // counter has moved, then a service must clear its upper part.
    repeat (10000) @(posedge clk_i);
    wb(1'b1, 18'h3fffc, xs());
    rd(18'h0000c, 32'h40000, 32'h7ffe0);
    for (i = 0; i < 9000 && sys_reset_o !== 1'b1; i++) @(posedge clk_i);
    check(i > 8160 && i < 8200, 1'b1);
    check(pin_w, 1'b0);
    for (j = 0; j < 100 && sys_reset_o === 1'b1 && pin_oe_n === 1'b0; j++)
      @(posedge clk_i);
    check(j, 32);
    check(irq_o, 1'b1);
    rd(18'h00004, 32'h1, 32'h1);
    rd(18'h00004, 32'h0, 32'h1);
    repeat (2) @(posedge clk_i);
    check(irq_o, 1'b0);
    // Disable bit: no reset however long we wait.
    wb(1'b1, 18'h00000, 32'h3);
    idle(9000, 0);
    wb(1'b1, 18'h00000, 32'h1);
    // Mode table: monitor, break, pin test, irq test, reset expected.
    for (k = 0; k < 4; k++) begin
      wb(1'b1, 18'h3fffc, xs());
      mode <= 4'(20'h9_a_6_5 >> (4 * (3 - k)));
      idle(9000, (k == 3) ? 1 : 0);
    end
    mode <= 4'h0;
    // Stop mode: prescaler cleared in the same cycle the clock to the counter stops.
    wb(1'b1, 18'h3fffc, xs());
    @(posedge clk_i);
    stop_exec_i <= 1'b1;
    stop_i      <= 1'b1;
    @(posedge clk_i);
    stop_exec_i <= 1'b0;
    rd(18'h0000c, 32'h40000, 32'h7ffff);
    idle(9000, 0);
    rd(18'h0000c, 32'h40000, 32'h7ffff);
    // Out of stop, a vector fetch must drop what the prescaler gathered.
    stop_i <= 1'b0;
    repeat (100) @(posedge clk_i);
    fetch_i <= 1'b1;
    @(posedge clk_i);
    fetch_i <= 1'b0;
    rd(18'h0000c, 32'h40000, 32'h7fff0);
    idle(9000, 1);
    // A mid-run internal reset returns registers and counters to zero.
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(18'h00000, 32'h0, 32'h3);
    rd(18'h00004, 32'h0, 32'h1);
    rd(18'h0000c, 32'h40000, 32'h7fff0);
    stop_test();
  end
endmodule
